// ---- inc/tw_pkg.sv ----
// Purpose: Shared constants, states and helpers for the two-wire channel.
// Assumes: 200 MHz system clock, six channels in the system.
// Notes:   Times are kept in ns and turned into cycle counts here.
`default_nettype none

package tw_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NUM_CH      = 6;   // Channels sharing the interrupt path
  localparam int TC_CH_LIM   = 4;   // Channels below this may start transfers
  localparam int FRAME_BITS  = 8;   // Data bits per frame
  localparam int FIFO_DEPTH  = 8;   // Transmit buffer words
  localparam int DATA_W      = 8;

  //////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int DATA_HOLD_NS  = 15;  // Output hold after clock fall
  // Least time, so rounded up to whole cycles
  localparam logic [2:0] HOLD_CYC =
    3'((DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  //////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_SHIFT  = 8'hff;  // Idle shifter sends ones
  localparam logic [3:0] RST_BITCNT = 4'h0;
  localparam logic [2:0] RST_HOLD   = 3'h0;
  localparam logic       RST_FLAG   = 1'b0;
  localparam logic [1:0] RST_LINES  = 2'h3;   // Both lines idle high

  //////////////////////////////////////////////////////////////////////////
  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_DATA = 4'b0010,
    ST_ACK  = 4'b0100,
    ST_WAIT = 4'b1000
  } tw_state_t;

  //////////////////////////////////////////////////////////////////////////
  // Fixed interrupt order, highest first: 2, 3, 0, 1, 4, 5
  localparam logic [2:0] PRIO_ORDER [NUM_CH] =
    '{3'h2, 3'h3, 3'h0, 3'h1, 3'h4, 3'h5};

  // Picks the winning channel; bit 3 says any request is pending
  function automatic logic [3:0] tw_prio_pick(input logic [5:0] req);
    logic [3:0] pick;
    pick = 4'h0;
    for (int k = NUM_CH - 1; k >= 0; k--) begin
      if (req[PRIO_ORDER[k]]) begin
        pick = {1'b1, PRIO_ORDER[k]};
      end
    end
    return pick;
  endfunction

endpackage

`default_nettype wire

// ---- hdl/tw_fifo.sv ----
// Purpose: Small transmit buffer with valid/ready on both sides.
// Assumes: One clock domain; DEPTH is a power of two.
// Notes:   Head word sits in an output register, so capacity is DEPTH+1.
`default_nettype none

module tw_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  // Fill side
  input  wire logic         i_wr_valid,
  output logic              o_wr_ready,
  input  wire logic [W-1:0] i_wr_data,
  // Drain side
  output logic              o_rd_valid,
  input  wire logic         i_rd_ready,
  output logic [W-1:0]      o_rd_data
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic [AW:0]  next_wr_ptr;
  logic [AW:0]  next_rd_ptr;
  logic         out_valid;
  logic         next_out_valid;
  logic [W-1:0] out_data;
  logic [W-1:0] next_out_data;
  logic         full;
  logic         empty;
  logic         push;
  logic         mem_pop;

  //////////////////////////////////////////////////////////////////////////
  // Pointer state; extra top bit tells full from empty
  always_comb begin
    full           = (wr_ptr ^ rd_ptr) == {1'b1, {AW{1'b0}}};
    empty          = wr_ptr == rd_ptr;
    push           = i_wr_valid && !full;
    mem_pop        = !empty && (!out_valid || i_rd_ready);
    next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr    = mem_pop ? rd_ptr + 1'b1 : rd_ptr;
    next_out_data  = mem_pop ? mem[rd_ptr[AW-1:0]] : out_data;
    next_out_valid = mem_pop || (out_valid && !i_rd_ready);
  end

  // Pointers and head register
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      out_valid <= next_out_valid;
      out_data  <= next_out_data;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= i_wr_data;
    end
  end

  assign o_wr_ready = !full;   // Back-pressure to the writer
  assign o_rd_valid = out_valid;
  assign o_rd_data  = out_data;

endmodule

`default_nettype wire

// ---- hdl/tw_channel.sv ----
// Purpose: One two-wire controller channel: line filters, frame
//          sequencer, status flags, transfer requests and interrupts.
// Assumes: Lines arrive from pins; the peer drives the bus clock.
// Notes:   Protocol addressing is outside; this is the byte engine.
//
// Notes on behaviour
// - Only channels zero to three may raise a transfer-controller request.
// - Request flag starts the controller; the interrupt flag does not.
// - Ack check off: set empty, interrupt, request flags after tx frames.
// - Ack check on: ack 0 sets all three; ack 1 sets interrupt only.
// - Controller service clears empty, interrupt and request flags.
// - Nack with ack check on: no controller request, CPU interrupt instead.
// - Stop seen while sending the trailing dummy byte clears state itself.
// - Each line passes two cascaded system-clock latches and a comparator.
// - Filter moves only when both latches agree, else holds.
// - Enable clear resets buffer flags, sequencer, hold counter, line drives.
// - Enable clear keeps registers, bit counter and raised interrupts.
// - Enable clear mid-frame stops at once and releases both lines.
// - Enable clear never writes bus busy; a stop waveform may clear it.
// - One interrupt request per channel, flag gated by interrupt enable bit.
// - Fixed channel priority 2, 3, 0, 1, 4, 5.
// - Buffer empty or full after a frame holds the clock line low.
`default_nettype none

module tw_channel
  import tw_pkg::*;
#(
  parameter int CH_ID   = 0,
  parameter int DEPTH   = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  // Two-wire pins, open drain, oe low while driving
  input  wire logic              i_scl,
  output logic                   o_scl_out,
  output logic                   o_scl_oe_n,
  input  wire logic              i_sda,
  output logic                   o_sda_out,
  output logic                   o_sda_oe_n,
  // Control bits
  input  wire logic              i_interface_enable_bit,
  input  wire logic              i_tx_mode,
  input  wire logic              i_ack_check_enable,
  input  wire logic              i_ack_out,
  input  wire logic              i_interface_interrupt_enable,
  // Transmit data into buffer
  input  wire logic              i_wr_valid,
  output logic                   o_wr_ready,
  input  wire logic [DATA_W-1:0] i_wr_data,
  // Receive data
  output logic [DATA_W-1:0]      o_rx_data,
  input  wire logic              i_rx_read,
  // Flag clearing
  input  wire logic              i_int_clear,
  input  wire logic              i_tc_done,
  // Status
  output logic                   o_tx_buffer_empty_flag,
  output logic                   o_rx_buffer_full_flag,
  output logic                   o_interface_interrupt_flag,
  output logic                   o_transfer_request_flag,
  output logic                   o_bus_busy_flag,
  output logic                   o_ack_received,
  output logic [3:0]             o_frame_bit_counter,
  // Transfer controller and interrupt controller
  output logic                   o_tc_req,
  output logic                   o_channel_interrupt_request,
  input  wire logic [NUM_CH-1:0] i_other_irq,
  output logic                   o_irq_pending,
  output logic [2:0]             o_irq_channel
);

  //////////////////////////////////////////////////////////////////////////
  // Line filters: index 0 is the clock line, 1 the data line
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] lat_a;
  logic [1:0] lat_b;
  logic [1:0] filt;
  logic [1:0] filt_q;
  logic [1:0] next_filt;

  // Two sync stages first, since the pins are asynchronous
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1  <= RST_LINES;
      sync2  <= RST_LINES;
      lat_a  <= RST_LINES;
      lat_b  <= RST_LINES;
      filt   <= RST_LINES;
      filt_q <= RST_LINES;
    end else begin
      sync1  <= {i_sda, i_scl};
      sync2  <= sync1;
      lat_a  <= sync2;
      lat_b  <= lat_a;
      filt   <= next_filt;
      filt_q <= filt;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_filt
      always_comb begin
        next_filt[gi] = (lat_a[gi] == lat_b[gi]) ? lat_a[gi] : filt[gi];
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Edge and condition detection
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  always_comb begin
    scl_rise  = filt[0] && !filt_q[0];
    scl_fall  = !filt[0] && filt_q[0];
    start_det = filt[0] && filt_q[0] && !filt[1] && filt_q[1];
    stop_det  = filt[0] && filt_q[0] && filt[1] && !filt_q[1];
  end

  //////////////////////////////////////////////////////////////////////////
  // Transmit buffer
  logic              fifo_valid;
  logic              fifo_ready;
  logic [DATA_W-1:0] fifo_data;

  tw_fifo #(
    .W     (DATA_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_clk      (i_clk),
    .i_rstn     (i_rstn),
    .i_wr_valid (i_wr_valid),
    .o_wr_ready (o_wr_ready),
    .i_wr_data  (i_wr_data),
    .o_rd_valid (fifo_valid),
    .i_rd_ready (fifo_ready),
    .o_rd_data  (fifo_data)
  );

  //////////////////////////////////////////////////////////////////////////
  // Frame sequencer
  tw_state_t         state;
  tw_state_t         next_state;
  logic [7:0]        shreg;
  logic [7:0]        next_shreg;
  logic [3:0]        bit_cnt;
  logic [3:0]        next_bit_cnt;
  logic [2:0]        hold_cnt;
  logic [2:0]        next_hold_cnt;
  logic              pend_low;
  logic              next_pend_low;
  logic              sda_low;
  logic              next_sda_low;
  logic              scl_hold;
  logic              next_scl_hold;
  logic              ack_rx;
  logic              next_ack_rx;
  logic [DATA_W-1:0] rx_data;
  logic [DATA_W-1:0] next_rx_data;
  logic              frame_end;
  logic              serviced;
  logic              en;
  logic              tx_empty;
  logic              rx_full;

  always_comb begin
    en            = i_interface_enable_bit;
    next_state    = state;
    next_shreg    = shreg;
    next_bit_cnt  = bit_cnt;
    next_hold_cnt = hold_cnt;
    next_pend_low = pend_low;
    next_sda_low  = sda_low;
    next_scl_hold = scl_hold;
    next_ack_rx   = ack_rx;
    next_rx_data  = rx_data;
    frame_end     = 1'b0;
    fifo_ready    = 1'b0;
    serviced      = i_tx_mode ? fifo_valid : !rx_full;
    if (!en) begin
      // release lines; bit counter kept as it is
      next_state    = ST_IDLE;
      next_hold_cnt = RST_HOLD;
      next_pend_low = 1'b0;
      next_sda_low  = 1'b0;
      next_scl_hold = 1'b0;
    end else if (stop_det) begin
      next_state    = ST_IDLE;
      next_hold_cnt = RST_HOLD;
      next_sda_low  = 1'b0;
      next_scl_hold = 1'b0;
    end else if (start_det) begin
      // Tx loads head word, or ones when nothing is queued
      next_state   = ST_DATA;
      next_bit_cnt = RST_BITCNT;
      next_sda_low = 1'b0;
      fifo_ready   = i_tx_mode;
      next_shreg   = (i_tx_mode && fifo_valid) ? fifo_data : RST_SHIFT;
    end else begin
      // Output change waits out the hold time after a clock fall
      if (hold_cnt != RST_HOLD) begin
        next_hold_cnt = hold_cnt - 3'h1;
        if (hold_cnt == 3'h1) begin
          next_sda_low = pend_low;
        end
      end
      case (state)
        ST_DATA: begin
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
            next_shreg   = {shreg[6:0], filt[1]};
          end else if (scl_fall) begin
            next_hold_cnt = HOLD_CYC;
            if (bit_cnt == 4'(FRAME_BITS)) begin
              // Ack slot: receiver answers, transmitter lets go
              next_state    = ST_ACK;
              next_pend_low = !i_tx_mode && !i_ack_out;
            end else begin
              next_pend_low = i_tx_mode && !shreg[7];
            end
          end
        end
        ST_ACK: begin
          if (scl_rise) begin
            next_ack_rx = filt[1];
          end else if (scl_fall) begin
            frame_end     = 1'b1;
            next_bit_cnt  = RST_BITCNT;
            next_pend_low = 1'b0;
            next_hold_cnt = HOLD_CYC;
            next_rx_data  = i_tx_mode ? rx_data : shreg;
            next_state    = ST_WAIT;
            next_scl_hold = 1'b1;
          end
        end
        ST_WAIT: begin
          if (serviced) begin
            next_state    = ST_DATA;
            next_scl_hold = 1'b0;
            fifo_ready    = i_tx_mode;
            next_shreg    = i_tx_mode ? fifo_data : shreg;
            next_hold_cnt = HOLD_CYC;
            next_pend_low = i_tx_mode && !fifo_data[7];
          end
        end
        ST_IDLE: begin
          next_state = ST_IDLE;
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state    <= ST_IDLE;
      shreg    <= RST_SHIFT;
      bit_cnt  <= RST_BITCNT;
      hold_cnt <= RST_HOLD;
      pend_low <= 1'b0;
      sda_low  <= 1'b0;
      scl_hold <= 1'b0;
      ack_rx   <= RST_FLAG;
      rx_data  <= '0;
    end else begin
      state    <= next_state;
      shreg    <= next_shreg;
      bit_cnt  <= next_bit_cnt;
      hold_cnt <= next_hold_cnt;
      pend_low <= next_pend_low;
      sda_low  <= next_sda_low;
      scl_hold <= next_scl_hold;
      ack_rx   <= next_ack_rx;
      rx_data  <= next_rx_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status flags; a set in the clearing cycle always wins
  logic tx_ev;
  logic rx_ev;
  logic set_all;
  logic int_flag;
  logic xreq;
  logic busy;
  logic next_tx_empty;
  logic next_rx_full;
  logic next_int_flag;
  logic next_xreq;
  logic next_busy;

  always_comb begin
    tx_ev   = frame_end && i_tx_mode;
    rx_ev   = frame_end && !i_tx_mode;
    set_all = tx_ev && (!i_ack_check_enable || !ack_rx);
    next_int_flag = tx_ev || rx_ev ||
                    (int_flag && !(i_int_clear || i_tc_done));
    next_xreq     = set_all || rx_ev ||
                    (xreq && !(i_int_clear || i_tc_done));
    next_tx_empty = set_all ||
                    (tx_empty && !(i_wr_valid || i_tc_done));
    next_rx_full  = rx_ev || (rx_full && !i_rx_read);
    if (!en) begin
      next_tx_empty = RST_FLAG;
      next_rx_full  = RST_FLAG;
    end
    next_busy = start_det ? 1'b1 : (stop_det ? 1'b0 : busy);
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_empty <= RST_FLAG;
      rx_full  <= RST_FLAG;
      int_flag <= RST_FLAG;
      xreq     <= RST_FLAG;
      busy     <= RST_FLAG;
    end else begin
      tx_empty <= next_tx_empty;
      rx_full  <= next_rx_full;
      int_flag <= next_int_flag;
      xreq     <= next_xreq;
      busy     <= next_busy;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Requests out of the channel
  logic [NUM_CH-1:0] irq_vec;
  logic [3:0]        pick;

  always_comb begin
    o_tc_req = xreq && (CH_ID < TC_CH_LIM);
    o_channel_interrupt_request = int_flag && i_interface_interrupt_enable;
    irq_vec        = i_other_irq;
    irq_vec[CH_ID] = o_channel_interrupt_request;
    pick          = tw_prio_pick(irq_vec);
    o_irq_pending = pick[3];
    o_irq_channel = pick[2:0];
  end

  //////////////////////////////////////////////////////////////////////////
  // Pins and status outputs
  assign o_scl_out  = 1'b0;       // Open drain: only ever pulls low
  assign o_sda_out  = 1'b0;
  assign o_scl_oe_n = !scl_hold;
  assign o_sda_oe_n = !sda_low;

  assign o_rx_data                  = rx_data;
  assign o_tx_buffer_empty_flag     = tx_empty;
  assign o_rx_buffer_full_flag      = rx_full;
  assign o_interface_interrupt_flag = int_flag;
  assign o_transfer_request_flag    = xreq;
  assign o_bus_busy_flag            = busy;
  assign o_ack_received             = ack_rx;
  assign o_frame_bit_counter        = bit_cnt;

endmodule

`default_nettype wire

// ---- dv/tw_channel_properties.sv ----
// Purpose: Concurrent checks on the ports of one two-wire channel.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   A frame end shows as the rise of the interrupt flag.
`default_nettype none

module tw_channel_properties
  import tw_pkg::*;
#(
  parameter int CH_ID = 0
) (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_rstn,
  // Controls
  input wire logic        i_interface_enable_bit,
  input wire logic        i_tx_mode,
  input wire logic        i_ack_check_enable,
  input wire logic        i_interface_interrupt_enable,
  input wire logic        i_int_clear,
  input wire logic        i_tc_done,
  input wire logic [5:0]  i_other_irq,
  // Status and requests
  input wire logic        o_scl_oe_n,
  input wire logic        o_sda_oe_n,
  input wire logic        o_tx_buffer_empty_flag,
  input wire logic        o_rx_buffer_full_flag,
  input wire logic        o_interface_interrupt_flag,
  input wire logic        o_transfer_request_flag,
  input wire logic        o_ack_received,
  input wire logic [3:0]  o_frame_bit_counter,
  input wire logic        o_tc_req,
  input wire logic        o_channel_interrupt_request,
  input wire logic        o_irq_pending,
  input wire logic [2:0]  o_irq_channel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  ////////////////////////////////////////////////////////////////////////
  // Own table of the winner, kept apart from the design's function
  localparam logic [2:0] ORD [6] = '{3'h2, 3'h3, 3'h0, 3'h1, 3'h4, 3'h5};
  logic [5:0] req;
  logic [3:0] win;

  // Highest-priority entry scanned last, so it wins
  always_comb begin
    req = i_other_irq;
    req[CH_ID] = o_channel_interrupt_request;
    win = 4'h0;
    for (int k = 5; k >= 0; k--) begin
      if (req[ORD[k]]) begin
        win = {1'b1, ORD[k]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit frame ends, told apart by the acknowledge outcome
  sequence frame_ok_s;
    $rose(o_interface_interrupt_flag) && i_tx_mode &&
    (!i_ack_check_enable || !o_ack_received);
  endsequence
  sequence frame_nack_s;
    $rose(o_interface_interrupt_flag) && i_tx_mode &&
    i_ack_check_enable && o_ack_received;
  endsequence

  tc_gate_a: assert property (
    o_tc_req == (o_transfer_request_flag && CH_ID < TC_CH_LIM))
    else $error("transfer request gating wrong");
  irq_gate_a: assert property (
    o_channel_interrupt_request ==
    (o_interface_interrupt_flag && i_interface_interrupt_enable))
    else $error("channel interrupt is not flag and enable");
  irq_order_a: assert property (
    o_irq_pending == win[3] && (!win[3] || o_irq_channel == win[2:0]))
    else $error("interrupt winner out of order");
  ack_ok_a: assert property (
    frame_ok_s |-> o_tx_buffer_empty_flag && o_transfer_request_flag)
    else $error("acked frame did not set all flags");
  nack_only_a: assert property (
    frame_nack_s |-> !o_transfer_request_flag ##1 !o_tc_req)
    else $error("nacked frame raised a transfer request");
  service_clr_a: assert property (
    i_tc_done |=> !o_tx_buffer_empty_flag &&
    !o_interface_interrupt_flag && !o_transfer_request_flag)
    else $error("service left a flag set");
  off_release_a: assert property (
    !i_interface_enable_bit |=> o_scl_oe_n && o_sda_oe_n)
    else $error("lines held while disabled");
  off_clear_a: assert property (
    !i_interface_enable_bit |=>
    !o_tx_buffer_empty_flag && !o_rx_buffer_full_flag)
    else $error("buffer flags kept while disabled");
  off_keep_a: assert property (
    !i_interface_enable_bit && !i_int_clear && !i_tc_done |=>
    $stable(o_frame_bit_counter) && $stable(o_interface_interrupt_flag))
    else $error("disable changed counter or interrupt flag");
  rx_stretch_a: assert property (
    $rose(o_rx_buffer_full_flag) |-> ##[0:2] !o_scl_oe_n)
    else $error("clock not held after full buffer");
endmodule

bind tw_channel tw_channel_properties #(.CH_ID(CH_ID))
  i_tw_channel_properties (
  .i_clk(i_clk), .i_rstn(i_rstn),
  .i_interface_enable_bit(i_interface_enable_bit), .i_tx_mode(i_tx_mode),
  .i_ack_check_enable(i_ack_check_enable),
  .i_interface_interrupt_enable(i_interface_interrupt_enable),
  .i_int_clear(i_int_clear), .i_tc_done(i_tc_done),
  .i_other_irq(i_other_irq), .o_scl_oe_n(o_scl_oe_n),
  .o_sda_oe_n(o_sda_oe_n), .o_tx_buffer_empty_flag(o_tx_buffer_empty_flag),
  .o_rx_buffer_full_flag(o_rx_buffer_full_flag),
  .o_interface_interrupt_flag(o_interface_interrupt_flag),
  .o_transfer_request_flag(o_transfer_request_flag),
  .o_ack_received(o_ack_received), .o_frame_bit_counter(o_frame_bit_counter),
  .o_tc_req(o_tc_req),
  .o_channel_interrupt_request(o_channel_interrupt_request),
  .o_irq_pending(o_irq_pending), .o_irq_channel(o_irq_channel)
);

`default_nettype wire

// ---- dv/tw_master_model.sv ----
// Purpose: Bus master on the two-wire link, driving clock and data.
// Assumes: Open-drain lines with pull-ups resolved by the bench.
// Notes:   Clock stands still between frames; the slave may stretch it.
`default_nettype none

module tw_master_model (
  // Resolved line levels
  input  wire logic i_scl,
  input  wire logic i_sda,
  // Master drive, 1 releases the line
  output var logic  o_scl,
  output var logic  o_sda
);
  timeunit 1ns;
  timeprecision 1ps;

  // Both lines released at power-up
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // Start: data falls while the clock is high
  task automatic start();
    o_sda = 1'b1;
    o_scl = 1'b1;
    #80 o_sda = 1'b0;
    #80 o_scl = 1'b0;
  endtask

  // Stop: waits out a stretch, then data rises with the clock high
  task automatic stop();
    #20 o_sda = 1'b0;
    #60 o_scl = 1'b1;
    wait (i_scl);
    #80 o_sda = 1'b1;
    #80;
  endtask

  // Nine bits MSB first; a 1 releases data so the slave may drive it.
  // Sampling waits 40 ns past the rise, since a stretch ends abruptly.
  task automatic xfer(input logic [8:0] v, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      #20 o_sda = v[i];
      #60 o_scl = 1'b1;
      wait (i_scl);
      #40 r[i] = i_sda;
      #40 o_scl = 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// ---- dv/testbench.sv ----
// Purpose: Self-checking bench for one two-wire channel.
// Assumes: Channel 0; the bench plays bus master, 160 ns per bit.
// Notes:   Sent bytes are read back on the data line by the master.
`default_nettype none

module testbench
  import tw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk = 1'b0;
  logic       rstn, en, txm, ackc, ie, wv, rxr, iclr, done, g, irq, ack;
  logic       scl_oe_n, sda_oe_n, m_scl, m_sda, wr_rdy, busy;
  logic [7:0] wd, rxd;
  logic [5:0] oirq;
  logic [3:0] bcnt, bsave, prio;
  logic [4:0] flg;
  logic [8:0] r;
  int         error_cnt = 0;
  int         total_checks = 0;
  int         cyc = 0;
  // Wired-AND with pull-ups; g injects a data-line glitch
  wire        scl = m_scl & scl_oe_n;
  wire        sda = m_sda & g & sda_oe_n;
  // Priority table: other requests, enable, expected winner
  localparam logic [10:0] PT [8] = '{
    {6'h00, 1'b1, 4'h8}, {6'h3e, 1'b1, 4'ha}, {6'h3a, 1'b1, 4'hb},
    {6'h32, 1'b1, 4'h8}, {6'h32, 1'b0, 4'h9}, {6'h30, 1'b0, 4'hc},
    {6'h21, 1'b0, 4'hd}, {6'h01, 1'b0, 4'h0}};

  always #2.5 clk = ~clk;

  tw_channel i_tw_channel (
    .i_clk(clk), .i_rstn(rstn), .i_scl(scl), .o_scl_out(),
    .o_scl_oe_n(scl_oe_n), .i_sda(sda), .o_sda_out(), .o_sda_oe_n(sda_oe_n),
    .i_interface_enable_bit(en), .i_tx_mode(txm), .i_ack_check_enable(ackc),
    .i_ack_out(1'b0), .i_interface_interrupt_enable(ie), .i_wr_valid(wv),
    .o_wr_ready(wr_rdy), .i_wr_data(wd), .o_rx_data(rxd), .i_rx_read(rxr),
    .i_int_clear(iclr), .i_tc_done(done),
    .o_tx_buffer_empty_flag(flg[4]), .o_rx_buffer_full_flag(flg[3]),
    .o_interface_interrupt_flag(flg[2]), .o_transfer_request_flag(flg[1]),
    .o_bus_busy_flag(busy), .o_ack_received(ack), .o_frame_bit_counter(bcnt),
    .o_tc_req(flg[0]), .o_channel_interrupt_request(irq),
    .i_other_irq(oirq), .o_irq_pending(prio[3]), .o_irq_channel(prio[2:0]));

  tw_master_model i_tw_master_model (
    .i_scl(scl), .i_sda(sda), .o_scl(m_scl), .o_sda(m_sda));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic push(input logic [7:0] d);
    @(negedge clk);
    wv = 1'b1;
    wd = d;
    @(negedge clk);
    wv = 1'b0;
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard, well past the expected run of about 4200 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, en, txm, ackc, ie, wv, rxr, iclr, done} = '0;
    g = 1'b1;
    wd = 8'h00;
    oirq = 6'h00;
    tick(6);
    rstn = 1'b1;
    tick(1);
    chk({flg, scl_oe_n, sda_oe_n, busy}, 8'h06);
    en = 1'b1;
    ie = 1'b1;
    // A one-cycle data glitch must not look like a start
    g = 1'b0;
    tick(1);
    g = 1'b1;
    tick(8);
    chk(busy, 1'b0);
    // Receive one byte; the channel acks low and holds the clock
    i_tw_master_model.start();
    chk(busy, 1'b1);
    i_tw_master_model.xfer({8'ha5, 1'b1}, r);
    tick(10);
    chk({r[0], rxd}, 9'h0a5);
    chk(flg, 5'h0f);
    chk(scl_oe_n, 1'b0);
    rxr = 1'b1;
    tick(1);
    rxr = 1'b0;
    tick(3);
    chk(scl_oe_n, 1'b1);
    iclr = 1'b1;
    tick(1);
    iclr = 1'b0;
    i_tw_master_model.stop();
    tick(10);
    chk(busy, 1'b0);
    // Fill at idle until refused; the tenth word is dropped
    txm = 1'b1;
    ackc = 1'b1;
    for (int k = 0; k < 10; k++) begin
      wv = 1'b1;
      wd = 8'h30 + 8'(k);
      tick(1);
    end
    wv = 1'b0;
    chk(wr_rdy, 1'b0);
    // Stream of acked frames, each serviced by the transfer controller
    i_tw_master_model.start();
    for (int k = 0; k < 9; k++) begin
      i_tw_master_model.xfer(9'h1fe, r);
      tick(10);
      chk(r[8:1], 8'h30 + 8'(k));
      chk({ack, flg}, 6'h17);
      done = 1'b1;
      tick(1);
      done = 1'b0;
      tick(1);
      chk(flg, 5'h00);
    end
    // Nack with checking on: interrupt only
    push(8'h5a);
    i_tw_master_model.xfer(9'h1ff, r);
    tick(10);
    chk({ack, flg}, 6'h24);
    for (int k = 0; k < 8; k++) begin
      {oirq, ie} = PT[k][10:4];
      tick(1);
      chk(prio, PT[k][3:0]);
      chk(irq, PT[k][4]);
    end
    ie = 1'b1;
    iclr = 1'b1;
    tick(1);
    iclr = 1'b0;
    // Nack with checking off still sets all three
    ackc = 1'b0;
    push(8'h00);
    i_tw_master_model.xfer(9'h1ff, r);
    tick(10);
    chk({ack, flg}, 6'h37);
    // Enable cleared mid-frame while the channel drives zeros
    push(8'h00);
    fork
      i_tw_master_model.xfer(9'h1ff, r);
    join_none
    tick(130);
    bsave = bcnt;
    en = 1'b0;
    tick(2);
    chk({scl_oe_n, sda_oe_n}, 2'h3);
    chk(flg, 5'h07);
    chk(bcnt, bsave);
    chk(busy, 1'b1);
    wait fork;
    // recovery: stop, two bit times, enable kept clear, restart
    i_tw_master_model.stop();
    tick(64);
    chk(busy, 1'b0);
    en = 1'b1;
    tick(4);
    chk({scl_oe_n, sda_oe_n}, 2'h3);
    conclude();
  end
endmodule

`default_nettype wire
